// ---- rtl/cih_pkg.sv ----
// constants shared by the interrupt handler, its checker and the bench
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus
package cih_pkg;
  localparam int          NUM_VEC       = 15;
  localparam logic [14:0] SRC_VALID     = 15'h5EFF;  // 13 live vector slots
  localparam logic [14:0] HW_AUTOCLR    = 15'h000F;  // external and timer 0/1 slots
  localparam int          EXT0_IDX      = 0;
  localparam int          EXT1_IDX      = 2;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam logic [15:0] VEC_STEP      = 16'h0008;
  localparam logic [2:0]  CALL_CYCLES   = 3'h4;
  localparam logic [4:0]  OFS_PENDING   = 5'h00;
  localparam logic [4:0]  OFS_ENABLE    = 5'h04;
  localparam logic [4:0]  OFS_PRIORITY  = 5'h08;
  localparam logic [4:0]  OFS_EXT_CFG   = 5'h0C;
  localparam logic [4:0]  OFS_STATUS    = 5'h10;
  localparam int          GLOBAL_EN_BIT = 15;
  localparam int          CFG_SENSE0    = 0;
  localparam int          CFG_POL0      = 1;
  localparam int          CFG_SENSE1    = 2;
  localparam int          CFG_POL1      = 3;
  localparam logic [14:0] PEND_RESET    = 15'h0000;
  localparam logic [14:0] EN_RESET      = 15'h0000;
  localparam logic [3:0]  CFG_RESET     = 4'h0;
endpackage

// ---- rtl/cih_ext_input.sv ----
// external interrupt pin conditioner: synchroniser, polarity and edge detect
// assumes the pin is asynchronous; only reads it, never drives it
`timescale 1ns/10ps
module cih_ext_input (
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  input  wire logic i_polarity,
  output logic      o_active,
  output logic      o_edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic act;
    logic edg;
  } cih_ext_state_t;

  cih_ext_state_t st_q, st_d;
  logic           level_now;

  always_comb begin
    st_d      = st_q;
    st_d.s1   = i_pin;
    st_d.s2   = st_q.s1;
    level_now = i_polarity ? st_q.s2 : ~st_q.s2;
    st_d.act  = level_now;
    st_d.edg  = level_now & ~st_q.act;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      // starts at the idle-high pin level so reset leaves no false edge behind
      st_q <= '{s1: 1'b1, s2: 1'b1, act: 1'b0, edg: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_active = st_q.act;
  assign o_edge   = st_q.edg;
endmodule // cih_ext_input

// ---- rtl/cih_top.sv ----
// interrupt handler: pending flags, enables, two priority levels, forced calls
// assumes the core pulses instruction completion and return completion
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module cih_top (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [14:0] i_src_event,
  input  wire logic        i_ext_irq_input_0,
  input  wire logic        i_ext_irq_input_1,
  input  wire logic        i_instr_done,
  input  wire logic        i_return_from_interrupt_done,
  output logic             o_call_valid,
  output logic      [15:0] o_call_vector,
  output logic             o_call_busy,
  output logic             o_in_service_hi,
  output logic             o_in_service_lo
);
  import cih_pkg::*;

  typedef struct packed {
    logic [14:0] pend;
    logic [14:0] en;
    logic        glob;
    logic [14:0] prio;
    logic [3:0]  cfg;
    logic        req_valid;
    logic [3:0]  req_idx;
    logic        req_hi;
    logic        hi_act;
    logic        lo_act;
    logic        block_one;
    logic [2:0]  call_cnt;
    logic        busy;
    logic        ack;
    logic        waitreq;
    logic [31:0] rdata;
    logic        call_valid;
    logic [15:0] call_vec;
  } cih_state_t;

  cih_state_t  st_q, st_d;
  logic        ext0_act, ext0_edge, ext1_act, ext1_edge;
  logic [14:0] elig, elig_hi, elig_lo, ev, lvl_mask, lvl_val;
  logic        wr_hit, rd_go;
  logic [3:0]  pick;
  logic [31:0] mrg;

  // lowest index wins among equal level requests
  function automatic logic [3:0] cih_first(input logic [14:0] v);
    logic [3:0] r;
    r = 4'hF;
    for (int k = NUM_VEC - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction

  // vector slots are eight bytes apart above the first one
  function automatic logic [15:0] cih_vector(input logic [3:0] idx);
    return VEC_BASE + (VEC_STEP * {12'h000, idx});
  endfunction

  // byte lanes that are not enabled keep their old contents
  function automatic logic [31:0] cih_merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // pins are only observed here; the pin routing elsewhere is untouched
  cih_ext_input u_ext0 (
    .i_clock    (i_clock),
    .i_resetn   (i_resetn),
    .i_pin      (i_ext_irq_input_0),
    .i_polarity (st_q.cfg[CFG_POL0]),
    .o_active   (ext0_act),
    .o_edge     (ext0_edge)
  );

  cih_ext_input u_ext1 (
    .i_clock    (i_clock),
    .i_resetn   (i_resetn),
    .i_pin      (i_ext_irq_input_1),
    .i_polarity (st_q.cfg[CFG_POL1]),
    .o_active   (ext1_act),
    .o_edge     (ext1_edge)
  );

  always_comb begin
    st_d          = st_q;
    st_d.call_valid = 1'b0;
    mrg           = 32'h00000000;
    rd_go         = (i_avs_read | i_avs_write) & ~st_q.ack;
    wr_hit        = i_avs_write & st_q.ack;
    pick          = 4'hF;

    // bus: one wait cycle, write and read data at the edge waitrequest is low
    st_d.ack      = rd_go;
    st_d.waitreq  = ~rd_go;
    if (rd_go && i_avs_read) begin
      case (i_avs_address)
        OFS_PENDING: begin
          st_d.rdata = {17'h00000, st_q.pend};
        end
        OFS_ENABLE: begin
          st_d.rdata = {16'h0000, st_q.glob, st_q.en};
        end
        OFS_PRIORITY: begin
          st_d.rdata = {17'h00000, st_q.prio};
        end
        OFS_EXT_CFG: begin
          st_d.rdata = {28'h0000000, st_q.cfg};
        end
        OFS_STATUS: begin
          st_d.rdata = {25'h0000000, st_q.block_one, st_q.lo_act, st_q.hi_act, st_q.req_idx};
        end
        default: begin
          st_d.rdata = 32'h00000000;
        end
      endcase
    end
    if (wr_hit) begin
      case (i_avs_address)
        OFS_PENDING: begin
          mrg       = cih_merge({17'h00000, st_q.pend}, i_avs_writedata, i_avs_byteenable);
          st_d.pend = mrg[14:0] & SRC_VALID;
        end
        OFS_ENABLE: begin
          mrg       = cih_merge({16'h0000, st_q.glob, st_q.en}, i_avs_writedata, i_avs_byteenable);
          st_d.glob = mrg[GLOBAL_EN_BIT];
          st_d.en   = mrg[14:0] & SRC_VALID;
        end
        OFS_PRIORITY: begin
          mrg       = cih_merge({17'h00000, st_q.prio}, i_avs_writedata, i_avs_byteenable);
          st_d.prio = mrg[14:0] & SRC_VALID;
        end
        OFS_EXT_CFG: begin
          mrg      = cih_merge({28'h0000000, st_q.cfg}, i_avs_writedata, i_avs_byteenable);
          st_d.cfg = mrg[3:0];
        end
        OFS_STATUS: begin
          // status is read only; a write there is dropped on purpose
          st_d.cfg = st_d.cfg;
        end
        default: begin
          st_d.cfg = st_d.cfg;
        end
      endcase
    end

    // request issued at instruction end; call takes four cycles
    if (st_q.call_cnt != 3'h0) begin
      st_d.call_cnt = st_q.call_cnt - 3'h1;
    end
    if (i_instr_done && st_q.req_valid && !st_q.block_one && st_q.call_cnt == 3'h0) begin
      st_d.call_valid = 1'b1;
      st_d.call_vec   = cih_vector(st_q.req_idx);
      st_d.call_cnt   = CALL_CYCLES;
      if (st_q.req_hi) begin
        st_d.hi_act = 1'b1;
      end else begin
        st_d.lo_act = 1'b1;
      end
      pick = st_q.req_idx;
      // only external edge flags and timer 0/1 flags self clear
      if (HW_AUTOCLR[st_q.req_idx]) begin
        st_d.pend[st_q.req_idx] = 1'b0;
      end
    end

    // busy is a flop of its own so the core never sees a decode glitch on it
    st_d.busy = (st_d.call_cnt != 3'h0);

    // return: drop the innermost level, then let one instruction run
    if (i_return_from_interrupt_done) begin
      if (st_q.hi_act) begin
        st_d.hi_act = 1'b0;
      end else begin
        st_d.lo_act = 1'b0;
      end
      st_d.block_one = 1'b1;
    end else if (i_instr_done && st_q.block_one) begin
      st_d.block_one = 1'b0;
    end

    // hardware sets win over software or vectoring clears
    ev            = i_src_event & SRC_VALID;
    ev[EXT0_IDX]  = st_q.cfg[CFG_SENSE0] & ext0_edge;
    ev[EXT1_IDX]  = st_q.cfg[CFG_SENSE1] & ext1_edge;
    st_d.pend     = st_d.pend | ev;
    lvl_mask      = 15'h0000;
    lvl_val       = 15'h0000;
    lvl_mask[EXT0_IDX] = ~st_q.cfg[CFG_SENSE0];
    lvl_mask[EXT1_IDX] = ~st_q.cfg[CFG_SENSE1];
    lvl_val[EXT0_IDX]  = ext0_act;
    lvl_val[EXT1_IDX]  = ext1_act;
    st_d.pend     = (st_d.pend & ~lvl_mask) | (lvl_val & lvl_mask);

    // detect stage: sampled every cycle from registered state, so a request
    // seen before a global clear can still go if the next instruction ends now
    elig    = st_q.glob ? (st_q.pend & st_q.en) : 15'h0000;
    elig_hi = 15'h0000;
    elig_lo = 15'h0000;
    // a running high routine is never preempted
    if (!st_q.hi_act) begin
      elig_hi = elig & st_q.prio;
    end
    // equal level waits for the return and one more instruction
    if (!st_q.hi_act && !st_q.lo_act) begin
      elig_lo = elig & ~st_q.prio;
    end
    if (elig_hi != 15'h0000) begin
      st_d.req_valid = 1'b1;
      st_d.req_hi    = 1'b1;
      st_d.req_idx   = cih_first(elig_hi);
    end else if (elig_lo != 15'h0000) begin
      st_d.req_valid = 1'b1;
      st_d.req_hi    = 1'b0;
      st_d.req_idx   = cih_first(elig_lo);
    end else begin
      st_d.req_valid = 1'b0;
      st_d.req_hi    = 1'b0;
      st_d.req_idx   = 4'hF;
    end
    // the just-taken request must not be offered twice
    if (st_d.call_valid && st_d.req_idx == pick) begin
      st_d.req_valid = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q.pend       <= PEND_RESET;
      st_q.en         <= EN_RESET;
      st_q.glob       <= 1'b0;
      st_q.prio       <= 15'h0000;
      st_q.cfg        <= CFG_RESET;
      st_q.req_valid  <= 1'b0;
      st_q.req_idx    <= 4'hF;
      st_q.req_hi     <= 1'b0;
      st_q.hi_act     <= 1'b0;
      st_q.lo_act     <= 1'b0;
      st_q.block_one  <= 1'b0;
      st_q.call_cnt   <= 3'h0;
      st_q.busy       <= 1'b0;
      st_q.ack        <= 1'b0;
      // waitrequest idles high so nothing looks answered while in reset
      st_q.waitreq    <= 1'b1;
      st_q.rdata      <= 32'h00000000;
      st_q.call_valid <= 1'b0;
      st_q.call_vec   <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_avs_readdata    = st_q.rdata;
  assign o_avs_waitrequest = st_q.waitreq;
  assign o_call_valid      = st_q.call_valid;
  assign o_call_vector     = st_q.call_vec;
  assign o_call_busy       = st_q.busy;
  assign o_in_service_hi   = st_q.hi_act;
  assign o_in_service_lo   = st_q.lo_act;
endmodule // cih_top

// ---- sim/cih_top_sva.sv ----
// checker on the interrupt handler top ports
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/10ps
module cih_top_sva import cih_pkg::*; (
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_instr_done,
  input wire logic        i_return_from_interrupt_done,
  input wire logic        o_call_valid,
  input wire logic [15:0] o_call_vector,
  input wire logic        o_call_busy,
  input wire logic        o_in_service_hi,
  input wire logic        o_in_service_lo
);
  logic       blk_q;
  logic [3:0] slot;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  assign slot = o_call_vector[6:3];
  // set by a return, cleared by the one instruction that must run after it
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) blk_q <= 1'b0;
    else if (i_return_from_interrupt_done) blk_q <= 1'b1;
    else if (i_instr_done) blk_q <= 1'b0;
  end
  a_call_after_instr: assert property (o_call_valid |-> $past(i_instr_done))
    else $error("call without instruction end");
  a_call_pulse: assert property (o_call_valid |=> !o_call_valid)
    else $error("call pulse too long");
  a_busy_span: assert property (o_call_valid |-> o_call_busy [*4] ##1 !o_call_busy)
    else $error("call busy span wrong");
  a_ret_gap: assert property (o_call_valid |-> !$past(blk_q))
    else $error("call right after return");
  a_hi_kept: assert property (o_call_valid |-> !$past(o_in_service_hi))
    else $error("high routine preempted");
  a_call_marks: assert property (o_call_valid |-> o_in_service_hi || o_in_service_lo)
    else $error("call without service level");
  a_vec_slot: assert property (o_call_valid |-> o_call_vector[2:0] == 3'h3 && SRC_VALID[slot])
    else $error("bad vector");
  a_bus_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  c_nested: cover property (o_in_service_hi && o_in_service_lo);
  c_reentry: cover property (i_return_from_interrupt_done ##[1:6] o_call_valid);
  c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule // cih_top_sva
bind cih_top cih_top_sva u_cih_top_sva (.*);

// ---- sim/cih_core_model.sv ----
// core stand-in: retires instructions, returns on request
// assumes call valid and busy come from the handler
`timescale 1ns/10ps
module cih_core_model (
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_call_valid,
  input  wire logic i_call_busy,
  input  wire logic i_ret,
  input  wire logic i_slow,
  output logic      o_instr_done,
  output logic      o_return_from_interrupt_done
);
  logic [1:0] wait_q;
  logic       ret_q;
  logic       slot;
  // nothing retires while the forced call runs
  assign slot = !i_call_valid && !i_call_busy && wait_q == 2'h0;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_q <= 2'h0;
      ret_q <= 1'b0;
      o_instr_done <= 1'b0;
      o_return_from_interrupt_done <= 1'b0;
    end else begin
      o_instr_done <= slot && !ret_q;
      o_return_from_interrupt_done <= slot && ret_q;
      ret_q <= (ret_q && !slot) || i_ret;
      wait_q <= slot && i_slow ? 2'h2 : wait_q - {1'b0, wait_q != 2'h0};
    end
  end
endmodule // cih_core_model

// ---- sim/cih_bench.sv ----
// self-checking bench: bus tasks, core stand-in, pins and peripheral pulses
// assumes design, checker and core model are compiled first
`timescale 1ns/10ps
module cih_bench;
  import cih_pkg::*;
  logic        i_clock = 1'b0, i_resetn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [4:0]  i_avs_address = '0;
  logic [31:0] i_avs_writedata = '0, o_avs_readdata, q;
  logic [3:0]  i_avs_byteenable = 4'hF;
  logic [14:0] i_src_event = '0;
  logic        i_ext_irq_input_0 = 1'b1, i_ext_irq_input_1 = 1'b1, ret = 1'b0, slow = 1'b0;
  logic        o_avs_waitrequest, i_instr_done, i_return_from_interrupt_done, o_call_valid, o_call_busy;
  logic        o_in_service_hi, o_in_service_lo;
  logic [15:0] o_call_vector;
  int          err_count = 0, checks_done = 0;
  always #5 i_clock = ~i_clock;
  cih_top u_cih_top (.*);
  cih_core_model u_cih_core_model (.i_clock, .i_resetn, .i_call_valid(o_call_valid), .i_call_busy(o_call_busy),
    .i_ret(ret), .i_slow(slow), .o_instr_done(i_instr_done), .o_return_from_interrupt_done(i_return_from_interrupt_done));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_clock);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    cyc(1);
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(nm, e, q);
  endtask
  task automatic wcall(input int s);
    int n;
    n = 0;
    while (o_call_valid !== 1'b1 && n < 40) begin
      @(posedge i_clock);
      n++;
    end
    chk("call", 1, o_call_valid);
    chk("busy", 1, o_call_busy);
    chk("vector", VEC_BASE + VEC_STEP * 16'(s), o_call_vector);
    cyc(1);
  endtask
  task automatic ncall(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge i_clock);
      if (o_call_valid !== 1'b0) k++;
    end
    chk("calls", 0, k);
  endtask
  task automatic doret;
    ret <= 1'b1;
    cyc(1);
    ret <= 1'b0;
  endtask
  task automatic t_regs;
    rchk("pend", OFS_PENDING, 32'(PEND_RESET));
    rchk("en", OFS_ENABLE, 32'(EN_RESET));
    rchk("cfg", OFS_EXT_CFG, 32'(CFG_RESET));
    rchk("unmapped", 5'h14, 32'h0);
    bus(1'b1, OFS_ENABLE, 32'hFFFF);
    rchk("reserved", OFS_ENABLE, {16'h0, 1'b1, SRC_VALID});
    bus(1'b1, OFS_ENABLE, 32'h0);
  endtask
  task automatic t_dis;
    i_src_event[5] <= 1'b1;
    cyc(1);
    i_src_event <= '0;
    ncall(10);
    rchk("set", OFS_PENDING, 32'h20);
    bus(1'b1, OFS_ENABLE, 32'h20);
    ncall(10);
    bus(1'b1, OFS_ENABLE, 32'h8020);
    wcall(5);
    rchk("kept", OFS_PENDING, 32'h20);
    doret;
    wcall(5);
    bus(1'b1, OFS_PENDING, 32'h0);
    doret;
    ncall(10);
  endtask
  task automatic t_pri;
    bus(1'b1, OFS_PRIORITY, 32'h2);
    bus(1'b1, OFS_ENABLE, 32'h8052);
    bus(1'b1, OFS_PENDING, 32'h50);
    wcall(4);
    bus(1'b1, OFS_PENDING, 32'h52);
    wcall(1);
    chk("svc", 2'h3, {o_in_service_hi, o_in_service_lo});
    rchk("status", OFS_STATUS, 32'h3F);
    rchk("prio", OFS_PRIORITY, 32'h2);
    rchk("autoclr", OFS_PENDING, 32'h50);
    slow <= 1'b1;
    doret;
    ncall(12);
    bus(1'b1, OFS_PENDING, 32'h0);
    doret;
    ncall(12);
    slow <= 1'b0;
  endtask
  task automatic t_ext;
    bus(1'b1, OFS_ENABLE, 32'h0);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, OFS_EXT_CFG, 32'(c) << 2);
      i_ext_irq_input_1 <= !c[1];
      cyc(8);
      bus(1'b1, OFS_PENDING, 32'h0);
      i_ext_irq_input_1 <= c[1];
      cyc(8);
      rchk("active", OFS_PENDING, 32'h4);
      i_ext_irq_input_1 <= !c[1];
      cyc(8);
      rchk("inactive", OFS_PENDING, c[0] ? 32'h4 : 32'h0);
    end
    bus(1'b1, OFS_EXT_CFG, 32'h3);
    i_ext_irq_input_0 <= 1'b0;
    i_ext_irq_input_1 <= 1'b1;
    cyc(8);
    bus(1'b1, OFS_PENDING, 32'h0);
    bus(1'b1, OFS_ENABLE, 32'h8001);
    i_ext_irq_input_0 <= 1'b1;
    wcall(EXT0_IDX);
    rchk("edgeclr", OFS_PENDING, 32'h0);
    doret;
    ncall(10);
  endtask
  initial begin
    cyc(3);
    i_resetn <= 1'b1;
    cyc(1);
    t_regs;
    t_dis;
    t_pri;
    t_ext;
    finish_test;
  end
  // whole run is well under two thousand cycles
  initial begin
    #20000;
    err_count++;
    finish_test;
  end
endmodule // cih_bench
